/* File: verilog/rcu_top.sv */
// Purpose: Reset control unit: merges reset causes, records them, drives
//          chip, system and debug resets and the processor run enable.
// Assumes: Pins and supply detectors are asynchronous; watchdog, core
//          request and lock state come from logic on aclk.
// Notes: The block itself is cleared only by aresetn, so its own
//        registers survive the resets it produces.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/100ps
module rcu_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire rcu_pkg::rcu_axi_req_t axi_req,
   output rcu_pkg::rcu_axi_rsp_t axi_rsp,
   input wire logic pin_reset_n,
   input wire logic power_on_reset_n,
   input wire logic low_voltage_reset_n,
   input wire logic debug_link_present,
   input wire logic watchdog_reset,
   input wire logic core_reset_request,
   input wire logic unlock_state,
   output logic chip_reset_n,
   output logic system_reset_n,
   output logic debug_reset_n,
   output logic core_run,
   output logic [31:0] reset_vector,
   output logic irq
);
   import rcu_pkg::*;

   rcu_state_s_t q;
   rcu_state_s_t d;
   logic master_src;
   logic sys_src;
   logic [6:0] evt;
   logic [11:0] raddr;
   logic wr_go;
   logic lane0;

   always_comb begin
      d = q;
      raddr = axi_req.araddr[11:0];
      // Three-stage synchronisers; a level counts once stages two and
      // three agree, which also filters single-cycle pin glitches.
      d.pin_sync = {q.pin_sync[1:0], pin_reset_n};
      d.por_sync = {q.por_sync[1:0], power_on_reset_n};
      d.lvr_sync = {q.lvr_sync[1:0], low_voltage_reset_n};
      d.dbg_sync = {q.dbg_sync[1:0], debug_link_present};
      if (q.pin_sync[2] == q.pin_sync[1]) begin
         d.pin_n = q.pin_sync[2];
      end
      if (q.por_sync[2] == q.por_sync[1]) begin
         d.por_n = q.por_sync[2];
      end
      if (q.lvr_sync[2] == q.lvr_sync[1]) begin
         d.lvr_n = q.lvr_sync[2]; // RULE2
      end
      if (q.dbg_sync[2] == q.dbg_sync[1]) begin
         d.dbg = q.dbg_sync[2];
      end

      master_src = !q.pin_n || !q.por_n || !q.lvr_n || q.soft_pend; // RULE1
      sys_src = q.wdg_pend || q.core_pend;

      // Causes seen this cycle; set wins over a clear in the same cycle.
      evt = 7'h00;
      evt[RCU_BIT_POR] = !q.por_n; // RULE12
      evt[RCU_BIT_PIN] = !q.pin_n; // RULE11
      evt[RCU_BIT_SOFT] = q.soft_pend; // RULE10
      evt[RCU_BIT_CORE] = q.core_pend; // RULE9
      evt[RCU_BIT_WDG] = q.wdg_pend; // RULE8

      // Requests from running logic are only taken while the core runs.
      if (q.st == RCU_ST_RUN) begin
         if (watchdog_reset) begin
            d.wdg_pend = 1'b1;
         end
         if (core_reset_request) begin
            d.core_pend = 1'b1; // RULE16
         end
      end

      // Trigger bit reads zero for one cycle after being written, then
      // recovers to one on its own.
      if (!q.trig) begin
         d.trig = 1'b1; // RULE5
      end

      case (q.st)
         RCU_ST_RUN: begin
            if (master_src) begin
               d.st = RCU_ST_CHIP;
               d.cnt = RCU_HOLD_CYC;
            end else if (sys_src) begin
               d.st = RCU_ST_SYS;
               d.cnt = RCU_HOLD_CYC;
            end
         end
         RCU_ST_CHIP: begin
            d.soft_pend = 1'b0;
            d.wdg_pend = 1'b0;
            d.core_pend = 1'b0;
            if (master_src) begin
               d.cnt = RCU_HOLD_CYC; // RULE2
            end else if (q.cnt == 8'h00) begin
               d.st = RCU_ST_RUN;
            end else begin
               d.cnt = q.cnt - 8'h01;
            end
         end
         RCU_ST_SYS: begin
            // Clearing the pending flags here is what keeps them from starting
            // another system reset once the state is back in run.
            d.wdg_pend = 1'b0; // RULE16
            d.core_pend = 1'b0;
            if (master_src) begin
               d.st = RCU_ST_CHIP;
               d.cnt = RCU_HOLD_CYC;
            end else if (q.cnt == 8'h00) begin
               d.st = RCU_ST_RUN;
            end else begin
               d.cnt = q.cnt - 8'h01;
            end
         end
         default: begin
            d.st = RCU_ST_CHIP;
            d.cnt = RCU_HOLD_CYC;
         end
      endcase

      d.chip_rst_n = (d.st != RCU_ST_CHIP); // RULE1
      d.sys_rst_n = (d.st == RCU_ST_RUN); // RULE6
      // Master reset always clears debug; system reset only without link.
      d.dbg_rst_n = d.chip_rst_n && (d.sys_rst_n || d.dbg); // RULE7
      d.core_run = (d.st == RCU_ST_RUN); // RULE13 RULE14

      // Write address and data are taken in either order.
      if (axi_req.awvalid && q.rsp.awready) begin
         d.aw_got = 1'b1;
         d.aw_addr = axi_req.awaddr[11:0];
      end
      if (axi_req.wvalid && q.rsp.wready) begin
         d.w_got = 1'b1;
         d.w_data = axi_req.wdata;
         d.w_strb = axi_req.wstrb;
      end
      if (q.rsp.bvalid && axi_req.bready) begin
         d.rsp.bvalid = 1'b0;
      end
      wr_go = q.aw_got && q.w_got && !q.rsp.bvalid;
      lane0 = q.w_strb[0];
      if (wr_go) begin
         d.aw_got = 1'b0;
         d.w_got = 1'b0;
         d.rsp.bvalid = 1'b1;
         d.rsp.bresp = RCU_RESP_OKAY;
         case (q.aw_addr)
            RCU_OFS_CTRL: begin
               // Zero triggers only while unlocked; one does nothing.
               if (lane0 && !q.w_data[RCU_BIT_TRIG] && unlock_state
                   && q.st == RCU_ST_RUN) begin // RULE3 RULE4 RULE15
                  d.trig = 1'b0;
                  d.soft_pend = 1'b1;
               end
            end
            RCU_OFS_CAUSE: begin
               if (lane0) begin
                  d.cause = q.cause & ~q.w_data[6:0]; // RULE17
               end
            end
            RCU_OFS_IRQ_EN: begin
               if (lane0) begin
                  d.irq_en = q.w_data[6:0];
               end
            end
            RCU_OFS_IRQ_CLR: begin
               if (lane0) begin
                  d.irq_sts = q.irq_sts & ~q.w_data[6:0];
               end
            end
            RCU_OFS_IRQ_STS: begin
               d.rsp.bresp = RCU_RESP_OKAY;
            end
            default: begin
               d.rsp.bresp = RCU_RESP_SLVERR;
            end
         endcase
      end
      d.cause = d.cause | evt; // RULE8 RULE9 RULE10 RULE11 RULE12
      d.irq_sts = d.irq_sts | evt;
      d.irq = |(d.irq_sts & d.irq_en);
      d.rsp.awready = !d.aw_got && !d.rsp.bvalid && !wr_go;
      d.rsp.wready = !d.w_got && !d.rsp.bvalid && !wr_go;

      // Reads answer one cycle after the address is taken.
      if (q.rsp.rvalid && axi_req.rready) begin
         d.rsp.rvalid = 1'b0;
      end
      if (axi_req.arvalid && q.rsp.arready) begin
         d.rsp.rvalid = 1'b1;
         d.rsp.rresp = RCU_RESP_OKAY;
         d.rsp.rdata = 32'h0000_0000;
         case (raddr)
            RCU_OFS_CTRL: d.rsp.rdata[RCU_BIT_TRIG] = q.trig;
            RCU_OFS_CAUSE: d.rsp.rdata[6:0] = q.cause;
            RCU_OFS_IRQ_STS: d.rsp.rdata[6:0] = q.irq_sts;
            RCU_OFS_IRQ_EN: d.rsp.rdata[6:0] = q.irq_en;
            RCU_OFS_IRQ_CLR: d.rsp.rdata = 32'h0000_0000;
            default: d.rsp.rresp = RCU_RESP_SLVERR;
         endcase
      end
      d.rsp.arready = !d.rsp.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= RCU_STATE_RST;
      end else begin
         q <= d;
      end
   end

   assign axi_rsp = q.rsp;
   assign chip_reset_n = q.chip_rst_n;
   assign system_reset_n = q.sys_rst_n;
   assign debug_reset_n = q.dbg_rst_n;
   assign core_run = q.core_run;
   assign reset_vector = RCU_RESET_VECTOR; // RULE14
   assign irq = q.irq;

endmodule

/* File: verilog/rcu_pkg.sv */
// Purpose: Constants, register map and carrier types of the reset control unit.
// Assumes: One 40 MHz clock, AXI4-Lite register access, 32-bit data.
// Notes: Reset sources are active low at the pins; flags sit in one word.
//
// How it works
// RULE1: Pin, power-on, soft trigger or brown-out reset chip.
// RULE2: Brown-out input holds master reset while low.
// RULE3: Writing zero to control bit zero resets chip.
// RULE4: Trigger write honoured only while system is unlocked.
// RULE5: Trigger bit returns to one by itself.
// RULE6: System reset spares these registers and attached debug.
// RULE7: Debug logic reset only when no debug link; the code also resets it in every chip reset, link or not.
// RULE8: Status bit six records watchdog reset, write-one clears.
// RULE9: Status bit three records core reset request.
// RULE10: Status bit two records software master reset.
// RULE11: Status bit one records reset pin cause.
// RULE12: Status bit zero records power-on, reads one initially.
// RULE13: Processor is halted while any reset is asserted.
// RULE14: Processor restarts in thread mode at vector four.
// RULE15: Software unlocks with key sequence outside this block.
// RULE16: Core reset request clears itself inside the reset.
// RULE17: Cause flags persist until software clears them.
package rcu_pkg;

   localparam logic [11:0] RCU_OFS_CTRL = 12'h000;
   localparam logic [11:0] RCU_OFS_CAUSE = 12'h004;
   localparam logic [11:0] RCU_OFS_IRQ_STS = 12'h008;
   localparam logic [11:0] RCU_OFS_IRQ_EN = 12'h00C;
   localparam logic [11:0] RCU_OFS_IRQ_CLR = 12'h010;

   localparam int RCU_BIT_TRIG = 0;
   localparam int RCU_BIT_POR = 0;
   localparam int RCU_BIT_PIN = 1;
   localparam int RCU_BIT_SOFT = 2;
   localparam int RCU_BIT_CORE = 3;
   localparam int RCU_BIT_WDG = 6;

   localparam logic [6:0] RCU_CAUSE_RST = 7'h01;
   localparam logic [6:0] RCU_IRQ_EN_RST = 7'h00;
   localparam logic [6:0] RCU_IRQ_STS_RST = 7'h00;
   localparam logic RCU_TRIG_RST = 1'b1;

   localparam logic [31:0] RCU_RESET_VECTOR = 32'h0000_0004;

   localparam logic [1:0] RCU_RESP_OKAY = 2'h0;
   localparam logic [1:0] RCU_RESP_SLVERR = 2'h2;

   // Reset outputs stay low at least this long after the last cause ends.
   localparam int RCU_HOLD_NS = 200;
   localparam int RCU_CLK_NS = 25;
   localparam int RCU_HOLD_CYC_I = (RCU_HOLD_NS + RCU_CLK_NS - 1) / RCU_CLK_NS;
   localparam logic [7:0] RCU_HOLD_CYC = 8'(RCU_HOLD_CYC_I);

   typedef enum logic [2:0] {
      RCU_ST_RUN = 3'h1,
      RCU_ST_CHIP = 3'h2,
      RCU_ST_SYS = 3'h4
   } rcu_state_t;

   typedef struct packed {
      logic awvalid;
      logic [31:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [31:0] araddr;
      logic rready;
   } rcu_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } rcu_axi_rsp_t;

   typedef struct packed {
      logic [2:0] pin_sync;
      logic [2:0] por_sync;
      logic [2:0] lvr_sync;
      logic [2:0] dbg_sync;
      logic pin_n;
      logic por_n;
      logic lvr_n;
      logic dbg;
      rcu_state_t st;
      logic [7:0] cnt;
      logic trig;
      logic soft_pend;
      logic wdg_pend;
      logic core_pend;
      logic [6:0] cause;
      logic [6:0] irq_sts;
      logic [6:0] irq_en;
      logic irq;
      logic chip_rst_n;
      logic sys_rst_n;
      logic dbg_rst_n;
      logic core_run;
      logic aw_got;
      logic [11:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      rcu_axi_rsp_t rsp;
   } rcu_state_s_t;

   localparam rcu_state_s_t RCU_STATE_RST = '{
      pin_sync: 3'h7, por_sync: 3'h7, lvr_sync: 3'h7, dbg_sync: 3'h0,
      pin_n: 1'b1, por_n: 1'b1, lvr_n: 1'b1, dbg: 1'b0,
      st: RCU_ST_CHIP, cnt: RCU_HOLD_CYC, trig: RCU_TRIG_RST,
      soft_pend: 1'b0, wdg_pend: 1'b0, core_pend: 1'b0,
      cause: RCU_CAUSE_RST, irq_sts: RCU_IRQ_STS_RST, irq_en: RCU_IRQ_EN_RST,
      irq: 1'b0, chip_rst_n: 1'b0, sys_rst_n: 1'b0, dbg_rst_n: 1'b0,
      core_run: 1'b0, aw_got: 1'b0, aw_addr: 12'h000, w_got: 1'b0,
      w_data: 32'h0000_0000, w_strb: 4'h0,
      rsp: '{awready: 1'b0, wready: 1'b0, bvalid: 1'b0, bresp: 2'h0,
             arready: 1'b0, rvalid: 1'b0, rdata: 32'h0000_0000,
             rresp: 2'h0}
   };

endpackage

/* File: testbench/rcu_top_monitor.sv */
// Purpose: Port assertions of the reset control unit.
// Assumes: One clock domain; aresetn clears the block.
// Notes: Synced inputs are given five cycles before a check binds.
`timescale 1ns/100ps
module rcu_top_monitor (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic pin_reset_n,
   input wire logic power_on_reset_n,
   input wire logic low_voltage_reset_n,
   input wire logic debug_link_present,
   input wire logic watchdog_reset,
   input wire logic core_reset_request,
   input wire logic chip_reset_n,
   input wire logic system_reset_n,
   input wire logic debug_reset_n,
   input wire logic core_run
);
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // The synchroniser needs four edges and the state one more, so the
   // reset output is looked at one cycle after the fifth low sample.
   a_master_cause: assert property (
      (!pin_reset_n || !power_on_reset_n)[*5] |=> !chip_reset_n)
      else $error("master reset missing");
   a_lvr_hold: assert property (
      (!low_voltage_reset_n)[*5] |=> !chip_reset_n)
      else $error("brown-out reset missing");
   a_chip_all: assert property (
      !chip_reset_n |-> !system_reset_n && !debug_reset_n)
      else $error("chip reset incomplete");
   a_halt_core: assert property (
      !system_reset_n || !chip_reset_n |-> !core_run)
      else $error("core runs in reset");
   a_wdg_sys: assert property (
      core_run && watchdog_reset |-> ##[1:3] !system_reset_n)
      else $error("watchdog reset missing");
   a_req_sys: assert property (
      core_run && core_reset_request |-> ##[1:3] !system_reset_n)
      else $error("core request reset missing");
   a_dbg_spare: assert property (
      debug_link_present[*5] ##0 ($fell(system_reset_n) && chip_reset_n)
      |-> debug_reset_n) else $error("debug reset with link");
   a_dbg_reset: assert property (
      (!debug_link_present)[*5] ##0 $fell(system_reset_n)
      |-> !debug_reset_n)
      else $error("debug kept without link");
   c_sys_only: cover property ($fell(system_reset_n) && chip_reset_n);
   c_chip: cover property ($fell(chip_reset_n));
   c_link: cover property (debug_link_present && !system_reset_n);
endmodule
bind rcu_top rcu_top_monitor i_mon (.aclk(aclk), .aresetn(aresetn),
   .pin_reset_n(pin_reset_n), .power_on_reset_n(power_on_reset_n),
   .low_voltage_reset_n(low_voltage_reset_n),
   .debug_link_present(debug_link_present),
   .watchdog_reset(watchdog_reset), .core_reset_request(core_reset_request),
   .chip_reset_n(chip_reset_n), .system_reset_n(system_reset_n),
   .debug_reset_n(debug_reset_n), .core_run(core_run));

/* File: testbench/rcu_partner.sv */
// Purpose: Far side model: lock logic, watchdog, core reset request.
// Assumes: Bench commands arrive on aclk.
// Notes: The lock falls back to locked in any system reset.
`timescale 1ns/100ps
module rcu_partner (
   input wire logic aclk,
   input wire logic system_reset_n,
   input wire logic wdg_go,
   input wire logic req_go,
   input wire logic key_v,
   input wire logic [7:0] key,
   output logic watchdog_reset,
   output logic core_reset_request,
   output logic unlock_state
);
   logic half_q = 1'b0;
   initial begin
      watchdog_reset = 1'b0;
      core_reset_request = 1'b0;
      unlock_state = 1'b0;
   end
   always @(posedge aclk) begin
      watchdog_reset <= wdg_go;
      if (!system_reset_n) begin
         core_reset_request <= 1'b0;
         unlock_state <= 1'b0;
         half_q <= 1'b0;
      end else begin
         if (req_go) core_reset_request <= 1'b1;
         if (key_v) begin
            half_q <= (key == 8'hAB);
            unlock_state <= (key == 8'h12) && (half_q || unlock_state);
         end
      end
   end
endmodule

/* File: testbench/testbench.sv */
// Purpose: Self-checking bench of the reset control unit.
// Assumes: Registers over AXI4-Lite; far side in rcu_partner.
// Notes: Waits are bounded; a spent bound counts as a failure.
`timescale 1ns/100ps
module testbench;
   import rcu_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic pin_n = 1'b1;
   logic por_n = 1'b0;
   logic lvr_n = 1'b1;
   logic dbg = 1'b0;
   logic wdg_go = 1'b0;
   logic req_go = 1'b0;
   logic key_v = 1'b0;
   logic [7:0] key = 8'h00;
   rcu_axi_req_t q = '0;
   rcu_axi_rsp_t r;
   logic wdg, creq, unl, chip_n, sys_n, dbg_n, run, irq;
   logic [31:0] vec;
   int failures = 0;
   int cmp_count = 0;
   always #12.5 aclk = ~aclk;
   rcu_top i_dut (.aclk(aclk), .aresetn(aresetn), .axi_req(q), .axi_rsp(r),
      .pin_reset_n(pin_n), .power_on_reset_n(por_n),
      .low_voltage_reset_n(lvr_n), .debug_link_present(dbg),
      .watchdog_reset(wdg), .core_reset_request(creq), .unlock_state(unl),
      .chip_reset_n(chip_n), .system_reset_n(sys_n), .debug_reset_n(dbg_n),
      .core_run(run), .reset_vector(vec), .irq(irq));
   rcu_partner i_far (.aclk(aclk), .system_reset_n(sys_n), .wdg_go(wdg_go),
      .req_go(req_go), .key_v(key_v), .key(key), .watchdog_reset(wdg),
      .core_reset_request(creq), .unlock_state(unl));
   task automatic finish_test();
      $display("failures %0d comparisons %0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, s);
      cmp_count++;
      if (s !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic tmo(input logic ok);
      if (!ok) begin
         failures++;
         finish_test();
      end
   endtask
   // Waits for the system reset level; release also needs the core running.
   task automatic wsys(input logic v);
      int n;
      n = 0;
      while (!(sys_n === v && (!v || run === 1'b1)) && n < 300) begin
         @(posedge aclk);
         n++;
      end
      tmo(n < 300);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
      input logic [1:0] e);
      int n;
      n = 0;
      q.awaddr <= {20'h00000, a};
      q.wdata <= d;
      q.wstrb <= 4'hF;
      q.awvalid <= 1'b1;
      q.wvalid <= 1'b1;
      q.bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (r.awready === 1'b1) q.awvalid <= 1'b0;
         if (r.wready === 1'b1) q.wvalid <= 1'b0;
      end while (r.bvalid !== 1'b1 && n < 50);
      q.bready <= 1'b0;
      tmo(n < 50);
      chk("bresp", e, r.bresp);
      @(posedge aclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      int n;
      n = 0;
      q.araddr <= {20'h00000, a};
      q.arvalid <= 1'b1;
      q.rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (r.arready === 1'b1) q.arvalid <= 1'b0;
      end while (r.rvalid !== 1'b1 && n < 50);
      q.rready <= 1'b0;
      tmo(n < 50);
      chk("rdata", e, r.rdata);
      chk("rresp", 32'h0, r.rresp);
      @(posedge aclk);
   endtask
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      por_n <= 1'b1;
      wsys(1'b1);
      chk("vector", 32'h00000004, vec);
      rd(12'h000, 32'h00000001);
      rd(12'h004, 32'h00000001);
      wr(12'h020, 32'h00000001, 2'h2);
      wr(12'h004, 32'h00000001, 2'h0);
      rd(12'h004, 32'h00000000);
      wr(12'h000, 32'h00000000, 2'h0);
      wr(12'h000, 32'h00000001, 2'h0);
      repeat (8) @(posedge aclk);
      chk("chip", 32'h1, chip_n);
      wr(12'h00C, 32'h0000007F, 2'h0);
      rd(12'h00C, 32'h0000007F);
      key_v <= 1'b1;
      key <= 8'hAB;
      @(posedge aclk);
      key <= 8'h12;
      @(posedge aclk);
      key_v <= 1'b0;
      wr(12'h000, 32'h00000000, 2'h0);
      wsys(1'b0);
      chk("chip", 32'h0, chip_n);
      chk("run", 32'h0, run);
      wsys(1'b1);
      rd(12'h000, 32'h00000001);
      rd(12'h004, 32'h00000004);
      chk("irq", 32'h1, irq);
      wr(12'h010, 32'h00000004, 2'h0);
      wr(12'h00C, 32'h00000000, 2'h0);
      chk("irq", 32'h0, irq);
      dbg <= 1'b1;
      repeat (6) @(posedge aclk);
      wdg_go <= 1'b1;
      @(posedge aclk);
      wdg_go <= 1'b0;
      wsys(1'b0);
      chk("debug", 32'h1, dbg_n);
      chk("chip", 32'h1, chip_n);
      wsys(1'b1);
      rd(12'h004, 32'h00000044);
      rd(12'h008, 32'h00000040);
      chk("irq", 32'h0, irq);
      dbg <= 1'b0;
      repeat (6) @(posedge aclk);
      req_go <= 1'b1;
      @(posedge aclk);
      req_go <= 1'b0;
      wsys(1'b0);
      chk("debug", 32'h0, dbg_n);
      wsys(1'b1);
      rd(12'h004, 32'h0000004C);
      pin_n <= 1'b0;
      wsys(1'b0);
      pin_n <= 1'b1;
      wsys(1'b1);
      lvr_n <= 1'b0;
      wsys(1'b0);
      repeat (20) @(posedge aclk);
      chk("chip", 32'h0, chip_n);
      lvr_n <= 1'b1;
      wsys(1'b1);
      rd(12'h004, 32'h0000004E);
      wr(12'h004, 32'h0000007F, 2'h0);
      rd(12'h004, 32'h00000000);
      finish_test();
   end
endmodule
